/* hdl/afx_defs.vh */
// constants of the alu and flow execution block: bus map, command fields,
// status flag positions, opcodes and execute cycle counts.
// assumes nothing; included by every design file that needs it.
`ifndef AFX_DEFS_VH
`define AFX_DEFS_VH

// register byte offsets on the apb side
`define AFX_OFF_CTRL 12'h000
`define AFX_OFF_STAT 12'h004
`define AFX_OFF_PC 12'h008
`define AFX_OFF_RET 12'h00c
`define AFX_OFF_RF 12'h080
`define AFX_RF_MASK 12'hf80

// command word fields (ctrl register)
`define AFX_F_OP_LSB 0
`define AFX_F_RD_LSB 4
`define AFX_F_RR_LSB 9
`define AFX_F_SKIP2 14
`define AFX_F_K_LSB 16
`define AFX_CMD_W 24

// status register layout and flag positions inside the flag byte
`define AFX_STAT_BUSY 0
`define AFX_STAT_SREG_LSB 8
`define AFX_SREG_C 0
`define AFX_SREG_Z 1
`define AFX_SREG_N 2
`define AFX_SREG_V 3
`define AFX_SREG_S 4
`define AFX_SREG_H 5

// reset values
`define AFX_RST_SREG 8'h00
`define AFX_RST_PC 16'h0000
`define AFX_RST_CMD 24'h000000

// opcodes
`define AFX_OP_ADD_CARRY 4'h0
`define AFX_OP_WORD_ADD_IMM 4'h1
`define AFX_OP_SUB_CONST 4'h2
`define AFX_OP_SUB_BORROW 4'h3
`define AFX_OP_SUB_BORROW_CONST 4'h4
`define AFX_OP_WORD_SUB_IMM 4'h5
`define AFX_OP_AND_CONST 4'h6
`define AFX_OP_OR_CONST 4'h7
`define AFX_OP_MASK_SET 4'h8
`define AFX_OP_MASK_CLEAR 4'h9
`define AFX_OP_TEST 4'ha
`define AFX_OP_MIXED_MUL 4'hb
`define AFX_OP_FRAC_MUL 4'hc
`define AFX_OP_PTR_JUMP 4'hd
`define AFX_OP_PTR_CALL 4'he
`define AFX_OP_CMP_SKIP 4'hf

// execute cycle counts
`define AFX_CYC_ONE 3'h1
`define AFX_CYC_TWO 3'h2
`define AFX_CYC_THREE 3'h3
`define AFX_CYC_FOUR 3'h4

// pointer register pair low index
`define AFX_PTR_LO 5'h1e

`endif

/* hdl/afx_regfile.v */
// general register file of the execution block: one register per entry,
// a pair read port, a byte read port and a pair write port with byte enables.
// assumes a single clock; read data are registered, so they follow one edge
// after the address is presented.
`timescale 1ns/1ps
`default_nettype none

module afx_regfile #(
  parameter DEPTH = 32,
  parameter AW = 5
) (
  input wire clk,
  input wire [AW-1:0] addr_a,
  input wire [AW-1:0] addr_b,
  input wire [1:0] we,
  input wire [AW-1:0] waddr,
  input wire [15:0] wdata,
  output reg [15:0] q_a,
  output reg [7:0] q_b
);

  wire [8*DEPTH-1:0] flat;
  wire [AW-1:0] addr_a1 = addr_a + {{(AW-1){1'b0}}, 1'b1};
  wire [AW-1:0] waddr1 = waddr + {{(AW-1){1'b0}}, 1'b1};

  // one byte per entry; the upper write byte lands on the next index (wraps)
  genvar i;
  generate
    for (i = 0; i < DEPTH; i = i + 1)
    begin : g_ent
      reg [7:0] ent_ff;
      always @(posedge clk)
      begin
        if (we[0] && (waddr == i))
          ent_ff <= wdata[7:0];
        else if (we[1] && (waddr1 == i))
          ent_ff <= wdata[15:8];
      end
      assign flat[8*i +: 8] = ent_ff;
    end
  endgenerate

  // registered reads, no reset needed on data storage
  always @(posedge clk)
  begin
    q_a <= {flat[8*addr_a1 +: 8], flat[8*addr_a +: 8]};
    q_b <= flat[8*addr_b +: 8];
  end

endmodule // afx_regfile

`default_nettype wire

/* hdl/afx_mixed_sign_multiply.v */
// signed by unsigned 8x8 multiplier with optional fractional left shift.
// assumes operands held stable by the caller; purely combinational.
`timescale 1ns/1ps
`default_nettype none

module afx_mixed_sign_multiply (
  input wire [7:0] mul_s,
  input wire [7:0] mul_u,
  input wire frac,
  output wire [15:0] product,
  output wire carry,
  output wire zero
);

  // unsigned operand gets a zero sign bit so the product stays exact
  wire signed [16:0] full = $signed(mul_s) * $signed({1'b0, mul_u});
  wire [15:0] raw = full[15:0];

  // carry is the top product bit before the fractional shift
  assign carry = raw[15];
  assign product = frac ? {raw[14:0], 1'b0} : raw;
  assign zero = (product == 16'h0000);

endmodule // afx_mixed_sign_multiply

`default_nettype wire

/* hdl/afx_core.v */
// alu and flow execution core: runs one command at a time written over apb,
// operating on the register file, the flag byte and the program counter.
// assumes an apb master on CLK_SYS and a synchronous active-high reset.
//
// Added by the designer: register access over APB and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "afx_defs.vh"

module afx_core #(
  parameter AW = 12,
  parameter RF_DEPTH = 32
) (
  input wire CLK_SYS,
  input wire SRST,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [AW-1:0] PADDR,
  input wire [31:0] PWDATA,
  output reg [31:0] PRDATA,
  output wire PREADY,
  output wire PSLVERR,
  output wire BUSY
);

  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_FETCH = 3'b010;
  localparam [2:0] ST_EXEC = 3'b100;

  reg [2:0] state_ff;
  reg [2:0] nxt_state;
  reg [`AFX_CMD_W-1:0] cmd_ff;
  reg [`AFX_CMD_W-1:0] nxt_cmd;
  reg [7:0] sreg_ff;
  reg [7:0] nxt_sreg;
  reg [15:0] pc_ff;
  reg [15:0] nxt_pc;
  reg [15:0] ret_ff;
  reg [15:0] nxt_ret;
  reg [2:0] cnt_ff;
  reg [2:0] nxt_cnt;
  reg rd_wait_ff;

  wire idle = state_ff[0];
  wire exec = state_ff[2];

  // command fields
  wire [3:0] op = cmd_ff[`AFX_F_OP_LSB +: 4];
  wire [4:0] rd_idx = cmd_ff[`AFX_F_RD_LSB +: 5];
  wire [4:0] rr_idx = cmd_ff[`AFX_F_RR_LSB +: 5];
  wire skip2 = cmd_ff[`AFX_F_SKIP2];
  wire [7:0] kimm = cmd_ff[`AFX_F_K_LSB +: 8];

  // apb address decode; anything else answers with an error
  wire sel_ctrl = (PADDR == `AFX_OFF_CTRL);
  wire sel_stat = (PADDR == `AFX_OFF_STAT);
  wire sel_pc = (PADDR == `AFX_OFF_PC);
  wire sel_ret = (PADDR == `AFX_OFF_RET);
  wire sel_rf = ((PADDR & `AFX_RF_MASK) == `AFX_OFF_RF) && (PADDR[1:0] == 2'b00);
  wire mapped = sel_ctrl | sel_stat | sel_pc | sel_ret | sel_rf;
  wire rf_rd = sel_rf & ~PWRITE;
  wire [4:0] apb_rf_idx = PADDR[6:2];

  // register file reads need one wait state, and are held off while busy
  // because port b then belongs to the operand fetch
  assign PREADY = ~rf_rd | rd_wait_ff;
  assign PSLVERR = PSEL & PENABLE & ~mapped;
  assign BUSY = ~idle;

  wire wr_fire = PSEL & PENABLE & PWRITE & mapped;

  always @(posedge CLK_SYS)
  begin
    if (SRST)
      rd_wait_ff <= 1'b0;
    else
      rd_wait_ff <= PSEL & PENABLE & rf_rd & ~rd_wait_ff & idle;
  end

  // register file and operand addressing
  wire is_ptr = (op == `AFX_OP_PTR_JUMP) || (op == `AFX_OP_PTR_CALL);
  wire [4:0] addr_a = is_ptr ? `AFX_PTR_LO : rd_idx;
  wire [4:0] addr_b = idle ? apb_rf_idx : rr_idx;
  wire [15:0] q_a;
  wire [7:0] q_b;
  reg [1:0] ex_we;
  reg [1:0] ex_we_q;
  reg [15:0] ex_res;
  reg [4:0] ex_waddr;

  // software writes only land while idle, so the two writers never meet
  wire apb_rf_we = wr_fire & sel_rf & idle;
  wire [1:0] rf_we = apb_rf_we ? 2'b01 : ex_we_q;
  wire [4:0] rf_waddr = apb_rf_we ? apb_rf_idx : ex_waddr;
  wire [15:0] rf_wdata = apb_rf_we ? {8'h00, PWDATA[7:0]} : ex_res;

  afx_regfile #(
    .DEPTH(RF_DEPTH),
    .AW(5)
  ) u_rf (
    .clk(CLK_SYS),
    .addr_a(addr_a),
    .addr_b(addr_b),
    .we(rf_we),
    .waddr(rf_waddr),
    .wdata(rf_wdata),
    .q_a(q_a),
    .q_b(q_b)
  );

  wire [15:0] mul_p;
  wire mul_c;
  wire mul_z;

  afx_mixed_sign_multiply u_mul (
    .mul_s(q_a[7:0]),
    .mul_u(q_b),
    .frac(op == `AFX_OP_FRAC_MUL),
    .product(mul_p),
    .carry(mul_c),
    .zero(mul_z)
  );

  // byte and word arithmetic shared by the add and subtract commands
  wire [7:0] da = q_a[7:0];
  wire cin = sreg_ff[`AFX_SREG_C];
  wire [8:0] add9 = {1'b0, da} + {1'b0, q_b} + {8'h00, cin};
  wire [4:0] addh = {1'b0, da[3:0]} + {1'b0, q_b[3:0]} + {4'h0, cin};
  wire sub_reg = (op == `AFX_OP_SUB_BORROW);
  wire use_bin = sub_reg || (op == `AFX_OP_SUB_BORROW_CONST);
  wire [7:0] sop = sub_reg ? q_b : kimm;
  wire bin = use_bin & cin;
  wire [8:0] sub9 = {1'b0, da} - {1'b0, sop} - {8'h00, bin};
  wire [4:0] subh = {1'b0, da[3:0]} - {1'b0, sop[3:0]} - {4'h0, bin};
  wire [16:0] wadd = {1'b0, q_a} + {9'h000, kimm};
  wire [16:0] wsub = {1'b0, q_a} - {9'h000, kimm};
  wire equal = (da == q_b);

  // per-command result, flags, pc and length; flags start from the old byte
  reg [7:0] flg;
  reg [7:0] lres;
  reg [15:0] wres;
  reg [15:0] ex_pc;
  reg [2:0] ex_len;
  reg ex_call;
  always @*
  begin
    flg = sreg_ff;
    lres = 8'h00;
    wres = 16'h0000;
    ex_res = 16'h0000;
    ex_we = 2'b00;
    ex_waddr = rd_idx;
    ex_pc = pc_ff + 16'h0001;
    ex_len = `AFX_CYC_ONE;
    ex_call = 1'b0;
    case (op)
      `AFX_OP_ADD_CARRY:
      begin
        ex_res = {8'h00, add9[7:0]};
        ex_we = 2'b01;
        flg[`AFX_SREG_C] = add9[8];
        flg[`AFX_SREG_Z] = (add9[7:0] == 8'h00);
        flg[`AFX_SREG_N] = add9[7];
        flg[`AFX_SREG_V] = (da[7] & q_b[7] & ~add9[7]) | (~da[7] & ~q_b[7] & add9[7]);
        flg[`AFX_SREG_H] = addh[4];
      end
      `AFX_OP_WORD_ADD_IMM, `AFX_OP_WORD_SUB_IMM:
      begin
        wres = (op == `AFX_OP_WORD_ADD_IMM) ? wadd[15:0] : wsub[15:0];
        ex_res = wres;
        ex_we = 2'b11;
        ex_len = `AFX_CYC_TWO;
        flg[`AFX_SREG_C] = (op == `AFX_OP_WORD_ADD_IMM) ? wadd[16] : wsub[16];
        flg[`AFX_SREG_Z] = (wres == 16'h0000);
        flg[`AFX_SREG_N] = wres[15];
        flg[`AFX_SREG_V] = (op == `AFX_OP_WORD_ADD_IMM) ? (~q_a[15] & wres[15]) : (q_a[15] & ~wres[15]);
        flg[`AFX_SREG_S] = flg[`AFX_SREG_N] ^ flg[`AFX_SREG_V];
      end
      `AFX_OP_SUB_CONST, `AFX_OP_SUB_BORROW, `AFX_OP_SUB_BORROW_CONST:
      begin
        ex_res = {8'h00, sub9[7:0]};
        ex_we = 2'b01;
        flg[`AFX_SREG_C] = sub9[8];
        // with borrow, zero chains so a multi-byte result tests as a whole
        flg[`AFX_SREG_Z] = (sub9[7:0] == 8'h00) & (~use_bin | sreg_ff[`AFX_SREG_Z]);
        flg[`AFX_SREG_N] = sub9[7];
        flg[`AFX_SREG_V] = (da[7] & ~sop[7] & ~sub9[7]) | (~da[7] & sop[7] & sub9[7]);
        flg[`AFX_SREG_H] = subh[4];
      end
      `AFX_OP_AND_CONST, `AFX_OP_OR_CONST, `AFX_OP_MASK_SET, `AFX_OP_MASK_CLEAR, `AFX_OP_TEST:
      begin
        case (op)
          `AFX_OP_AND_CONST: lres = da & kimm;
          `AFX_OP_OR_CONST: lres = da | kimm;
          `AFX_OP_MASK_SET: lres = da | kimm;
          `AFX_OP_MASK_CLEAR: lres = da & ~kimm;
          default: lres = da & da;
        endcase
        ex_res = {8'h00, lres};
        ex_we = 2'b01;
        // carry, half carry and sign are left alone here
        flg[`AFX_SREG_Z] = (lres == 8'h00);
        flg[`AFX_SREG_N] = lres[7];
        flg[`AFX_SREG_V] = 1'b0;
      end
      `AFX_OP_MIXED_MUL, `AFX_OP_FRAC_MUL:
      begin
        ex_res = mul_p;
        ex_we = 2'b11;
        ex_waddr = 5'h00;
        ex_len = `AFX_CYC_TWO;
        flg[`AFX_SREG_C] = mul_c;
        flg[`AFX_SREG_Z] = mul_z;
      end
      `AFX_OP_PTR_JUMP:
      begin
        ex_pc = q_a;
        ex_len = `AFX_CYC_TWO;
      end
      `AFX_OP_PTR_CALL:
      begin
        ex_pc = q_a;
        ex_call = 1'b1;
        ex_len = `AFX_CYC_FOUR;
      end
      `AFX_OP_CMP_SKIP:
      begin
        // skipping costs one extra cycle per word skipped
        if (equal)
        begin
          ex_pc = pc_ff + (skip2 ? 16'h0003 : 16'h0002);
          ex_len = skip2 ? `AFX_CYC_THREE : `AFX_CYC_TWO;
        end
      end
      default:
      begin
        ex_len = `AFX_CYC_ONE;
      end
    endcase
  end

  wire ex_done = exec && (cnt_ff == ex_len);
  wire [1:0] ex_we_gated = ex_done ? ex_we : 2'b00;

  // sequencer: a command is latched while idle, operands read, then executed
  always @*
  begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_cmd = cmd_ff;
    case (state_ff)
      ST_IDLE:
      begin
        if (wr_fire && sel_ctrl)
        begin
          nxt_cmd = PWDATA[`AFX_CMD_W-1:0];
          nxt_state = ST_FETCH;
        end
      end
      ST_FETCH:
      begin
        nxt_cnt = `AFX_CYC_ONE;
        nxt_state = ST_EXEC;
      end
      ST_EXEC:
      begin
        if (ex_done)
          nxt_state = ST_IDLE;
        else
          nxt_cnt = cnt_ff + 3'h1;
      end
      default:
      begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // architectural state: commits at the last execute cycle, software
  // writes to flags and pc are honoured only while idle
  always @*
  begin
    nxt_sreg = sreg_ff;
    nxt_pc = pc_ff;
    nxt_ret = ret_ff;
    if (ex_done)
    begin
      nxt_sreg = flg;
      nxt_pc = ex_pc;
      if (ex_call)
        nxt_ret = pc_ff + 16'h0001;
    end
    else if (idle && wr_fire && sel_stat)
      nxt_sreg = PWDATA[`AFX_STAT_SREG_LSB +: 8];
    else if (idle && wr_fire && sel_pc)
      nxt_pc = PWDATA[15:0];
  end

  always @(posedge CLK_SYS)
  begin
    if (SRST)
    begin
      state_ff <= ST_IDLE;
      cnt_ff <= 3'h0;
      cmd_ff <= `AFX_RST_CMD;
      sreg_ff <= `AFX_RST_SREG;
      pc_ff <= `AFX_RST_PC;
      ret_ff <= `AFX_RST_PC;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      cmd_ff <= nxt_cmd;
      sreg_ff <= nxt_sreg;
      pc_ff <= nxt_pc;
      ret_ff <= nxt_ret;
    end
  end

  // execute writes go to the register file only on the completing cycle
  always @*
  begin
    ex_we_q = ex_we_gated;
  end

  // read mux over flops; unmapped reads return zero
  always @*
  begin
    PRDATA = 32'h00000000;
    if (sel_ctrl)
      PRDATA = {{(32-`AFX_CMD_W){1'b0}}, cmd_ff};
    else if (sel_stat)
      PRDATA = {16'h0000, sreg_ff, 7'h00, ~idle};
    else if (sel_pc)
      PRDATA = {16'h0000, pc_ff};
    else if (sel_ret)
      PRDATA = {16'h0000, ret_ff};
    else if (sel_rf)
      PRDATA = {24'h000000, q_b};
  end

endmodule // afx_core

`default_nettype wire

/* tb/afx_core_assertions.sv */
// bus and command timing checks for the execution core.
// assumes a master that holds each request until pready.
`timescale 1ns/1ps
`default_nettype none
module afx_core_assertions #(
  parameter AW = 12
) (
  input wire logic CLK_SYS,
  input wire logic SRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [AW-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic BUSY
);
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (SRST);
  // request decode; a command starts only from idle
  logic acc;
  logic go;
  logic rfa;
  logic [3:0] op;
  assign acc = PSEL && PENABLE;
  assign go = acc && PWRITE && PADDR == 12'h000 && !BUSY;
  assign rfa = (PADDR & 12'hf83) == 12'h080;
  assign op = PWDATA[3:0];
  // busy spans the fetch cycle plus the execute cycles
  sequence run2_s;
    BUSY [*2] ##1 !BUSY;
  endsequence
  sequence run3_s;
    BUSY [*3] ##1 !BUSY;
  endsequence
  sequence wait_s;
    !PREADY ##1 PREADY;
  endsequence
  one_cyc_a: assert property (go && op inside {4'h0, 4'h2, 4'h3, 4'h4, [4'h6:4'ha]} |=> run2_s)
    else $error("one cycle command has wrong length");
  two_cyc_a: assert property (go && op inside {4'h1, 4'h5, [4'hb:4'hd]} |=> run3_s)
    else $error("two cycle command has wrong length");
  call_cyc_a: assert property (go && op == 4'he |=> BUSY [*5] ##1 !BUSY)
    else $error("call has wrong length");
  skip_cyc_a: assert property (go && op == 4'hf |=> BUSY [*2] ##[1:3] !BUSY)
    else $error("compare skip has wrong length");
  busy_cause_a: assert property ($rose(BUSY) |-> $past(go))
    else $error("busy rose without a command");
  map_err_a: assert property (acc |-> PSLVERR == !(rfa || PADDR < 12'h010 && PADDR[1:0] == 2'b00))
    else $error("slave error does not match the map");
  err_data_a: assert property (acc && PSLVERR |-> PRDATA == 32'h0)
    else $error("refused access returned data");
  wr_ready_a: assert property (acc && PWRITE |-> PREADY)
    else $error("write was stalled");
  rf_wait_a: assert property (PSEL && !PENABLE && !PWRITE && rfa && !BUSY |=> wait_s)
    else $error("register file read wait wrong");
endmodule // afx_core_assertions

bind afx_core afx_core_assertions #(.AW(AW)) u_afx_core_assertions (.CLK_SYS(CLK_SYS), .SRST(SRST),
  .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .BUSY(BUSY));
`default_nettype wire

/* tb/afx_core_bench.sv */
// self-checking bench for afx_core: apb driver, reference model, monitor.
// assumes busy drops after every command and reads always complete.
`timescale 1ns/1ps
`default_nettype none
module afx_core_bench;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  wire [31:0] prdata;
  wire pready;
  wire pslverr;
  wire busy;
  int num_errors = 0;
  int checks_done = 0;
  int seed = 86450;
  int bcnt = 0;
  logic [63:0] q[$];
  logic [7:0] rf[32];
  logic [7:0] sr = 8'h00;
  logic [15:0] pc = 16'h0000;
  logic [15:0] ret = 16'h0000;
  afx_core u_afx_core (.CLK_SYS(clk_sys), .SRST(srst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .BUSY(busy));
  // 100 mhz clock
  always #5 clk_sys = ~clk_sys;
  // busy length is counted here so the driver may keep issuing transfers
  always @(posedge clk_sys)
    if (busy === 1'b1) bcnt <= bcnt + 1;
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e)
    begin
      num_errors++;
      $display("[ERR] %0t seen %h exp %h", $time, s, e);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // one transfer; a read notes {mask, expected}, then an idle cycle follows
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [63:0] e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    if (!w) q.push_back(e);
    // no wait limit here; only the watchdog ends a hung transfer
    do
      @(posedge clk_sys);
    while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
    apb(1'b0, a, 32'h0, {m, e & m});
  endtask
  function automatic logic [11:0] ra(input logic [4:0] n);
    return 12'h080 + {n, 2'b00};
  endfunction
  // monitor: each completed read retires the oldest note
  always @(posedge clk_sys)
  begin : mon_b
    logic [63:0] e;
    if (psel && penable && pready === 1'b1 && !pwrite)
    begin
      e = q.pop_front();
      check(prdata & e[63:32], e[31:0]);
    end
  end
  // reference model of one command; returns its execute cycles
  task automatic model(input logic [3:0] op, input logic [4:0] d, input logic [4:0] r, input logic [7:0] k,
      input logic sk, output int n);
    logic [7:0] a;
    logic [7:0] b;
    logic [7:0] y;
    logic [7:0] h;
    logic [16:0] w;
    logic [15:0] p;
    logic c;
    a = rf[d];
    b = (op == 4'h0 || op == 4'h3) ? rf[r] : k;
    c = sr[0] && (op == 4'h0 || op == 4'h3 || op == 4'h4);
    h = rf[d + 5'd1];
    n = 1;
    y = a;
    pc = pc + 16'h1;
    case (op)
      4'h0:
      begin
        {sr[0], y} = a + b + c;
        sr[5] = {1'b0, a[3:0]} + b[3:0] + c > 5'hf;
        sr[3] = a[7] == b[7] && y[7] != a[7];
        sr[1] = y == 8'h0;
      end
      4'h2, 4'h3, 4'h4:
      begin
        {sr[0], y} = {1'b0, a} - b - c;
        sr[5] = {1'b0, a[3:0]} < b[3:0] + c;
        sr[3] = a[7] != b[7] && y[7] != a[7];
        sr[1] = y == 8'h0 && (op == 4'h2 || sr[1]);
      end
      4'h1, 4'h5:
      begin
        n = 2;
        w = op == 4'h1 ? {h, a} + k : {1'b0, h, a} - k;
        sr[3] = op == 4'h1 ? !h[7] && w[15] : h[7] && !w[15];
        sr[0] = w[16];
        sr[1] = w[15:0] == 16'h0;
        sr[2] = w[15];
        sr[4] = w[15] ^ sr[3];
        {rf[d + 5'd1], rf[d]} = w[15:0];
      end
      4'hb, 4'hc:
      begin
        n = 2;
        p = $signed(a) * $signed({1'b0, rf[r]});
        sr[0] = p[15];
        if (op == 4'hc) p = p << 1;
        sr[1] = p == 16'h0;
        {rf[1], rf[0]} = p;
      end
      4'hd, 4'he:
      begin
        n = op == 4'hd ? 2 : 4;
        if (op == 4'he) ret = pc;
        pc = {rf[31], rf[30]};
      end
      4'hf:
        if (a == rf[r])
        begin
          n = sk ? 3 : 2;
          pc = pc + (sk ? 16'h2 : 16'h1);
        end
      default:
      begin
        y = op == 4'h6 ? a & k : op == 4'h9 ? a & ~k : op == 4'ha ? a : a | k;
        sr[3] = 1'b0;
        sr[1] = y == 8'h0;
      end
    endcase
    if (op < 4'hb && op != 4'h1 && op != 4'h5)
    begin
      rf[d] = y;
      sr[2] = y[7];
    end
  endtask
  initial
  begin : main_b
    int n;
    int b0;
    logic [4:0] d;
    logic [4:0] r;
    logic [7:0] k;
    logic [7:0] f;
    logic [11:0] al[6] = '{12'h000, 12'h004, 12'h008, 12'h00c, 12'h010, 12'h082};
    repeat (10) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    // reset values; writes to read-only and unmapped places leave no trace
    apb(1'b1, 12'h00c, 32'hffffffff, 64'h0);
    apb(1'b1, 12'h010, 32'hffffffff, 64'h0);
    foreach (al[i]) rd(al[i], 32'h0, 32'hffffffff);
    $display("reset test done");
    for (int i = 0; i < 32; i++)
    begin
      rf[i] = $random(seed);
      apb(1'b1, ra(i[4:0]), {24'h0, rf[i]}, 64'h0);
    end
    // every opcode four times; half the runs use equal operands
    for (int i = 0; i < 64; i++)
    begin
      d = $random(seed);
      r = i[4] ? d : 5'($random(seed));
      k = i[4] ? rf[d] : 8'($random(seed));
      f = $random(seed);
      apb(1'b1, 12'h004, {16'h0, f, 8'h00}, 64'h0);
      sr = f;
      pc = $random(seed);
      apb(1'b1, 12'h008, {16'h0, pc}, 64'h0);
      b0 = bcnt;
      apb(1'b1, 12'h000, {8'h00, k, 1'b0, i[5], r, d, i[3:0]}, 64'h0);
      if (i[3:0] == 4'he) apb(1'b1, 12'h008, 32'h0000ffff, 64'h0);
      model(i[3:0], d, r, k, i[5], n);
      while (busy !== 1'b0)
        @(posedge clk_sys);
      check(bcnt - b0, n + 1);
      rd(12'h004, {16'h0, sr, 8'h00}, 32'h0000ff01);
      rd(12'h008, {16'h0, pc}, 32'hffffffff);
      rd(12'h00c, {16'h0, ret}, 32'hffffffff);
      rd(ra(d), {24'h0, rf[d]}, 32'h000000ff);
      rd(ra(d + 5'd1), {24'h0, rf[d + 5'd1]}, 32'h000000ff);
      rd(ra(5'd0), {24'h0, rf[0]}, 32'h000000ff);
      rd(ra(5'd1), {24'h0, rf[1]}, 32'h000000ff);
    end
    $display("command test done");
    stop_test();
  end
  // watchdog: the whole run needs well under 50000 cycles
  initial
  begin
    #500000;
    num_errors++;
    stop_test();
  end
endmodule // afx_core_bench
`default_nettype wire
